/* File: hdl/amcs_sequencer.sv */
// Mode decode, channel sequencing and result buffering for a three-input front end.
`timescale 1ns/1ps
`include "amcs_regs.svh"

module amcs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `AMCS_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_i,
   // Filling side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Draining side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || WIDTH < 1)
   begin : g_bad_shape
      $error("amcs_fifo needs a depth of at least two and a width of at least one.");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   wire              do_wr = in_valid_i && in_ready_o;
   wire              do_rd = out_valid_o && out_ready_i;
   wire  [AW-1:0]    wr_nxt = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
   wire  [AW-1:0]    rd_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;

   assign in_ready_o  = (count_r != (AW + 1)'(DEPTH));
   assign out_valid_o = (count_r != '0);
   assign out_data_o  = mem_r[rd_ptr_r];

   always_ff @(posedge clock_i)
   begin
      if (do_wr)
         mem_r[wr_ptr_r] <= in_data_i;
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end
      else
      begin
         if (do_wr)
            wr_ptr_r <= wr_nxt;
         if (do_rd)
            rd_ptr_r <= rd_nxt;
         count_r <= count_r + (AW + 1)'(do_wr) - (AW + 1)'(do_rd);
      end
   end
endmodule : amcs_fifo

module amcs_sequencer #(
   parameter int FIFO_DEPTH = `AMCS_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                                          clock_i,
   input  wire logic                                          rst_i,
   // Configuration register port
   input  wire logic                                          cfg_wr_i,
   input  wire logic [7:0]                                    cfg_wdata_i,
   output logic      [7:0]                                    cfg_rdata_o,
   input  wire logic                                          clk_ratio_3x_i,
   input  wire amcs_pkg::amcs_coef_t [`AMCS_NUM_SETS-1:0]     coef_i,
   output amcs_pkg::amcs_status_t                             status_o,
   // Sensor side pins
   input  wire logic                                          input_pixel_clock_i,
   input  wire logic                                          external_line_start_input_i,
   input  wire logic [`AMCS_DATA_W-1:0]                       red_analog_input_i,
   input  wire logic [`AMCS_DATA_W-1:0]                       green_analog_input_i,
   input  wire logic [`AMCS_DATA_W-1:0]                       blue_analog_input_i,
   // Converter side
   output logic                                               line_start_pulse_o,
   output logic                                               adc_strobe_o,
   output logic      [1:0]                                    mux_sel_o,
   // Result stream
   output logic                                               conv_valid_o,
   input  wire logic                                          conv_ready_i,
   output amcs_pkg::amcs_conv_t                               conv_o
);
   import amcs_pkg::*;
   localparam int DW = `AMCS_DATA_W;

   if (FIFO_DEPTH < 2)
   begin : g_bad_depth
      $error("amcs_sequencer needs a result buffer of at least two words.");
   end

   function automatic amcs_mode_t decode_mode(input logic [1:0] bits);
      amcs_mode_t m;
      unique case (bits)
         2'h3: m = amcs_mode_pix3;
         2'h2: m = amcs_mode_pix2;
         2'h1: m = amcs_mode_line1;
         2'h0: m = amcs_mode_line3;
      endcase
      return m;
   endfunction : decode_mode

   // Saturating gain then offset; gain has a fixed binary point.
   function automatic logic [DW-1:0] proc_sample(input logic [DW-1:0] s, input amcs_coef_t c);
      logic        [DW+`AMCS_GAIN_W-1:0] prod;
      logic signed [DW+2:0]              sum;
      prod = s * c.gain;
      sum  = $signed({1'b0, prod[DW+`AMCS_GAIN_W-1:`AMCS_GAIN_FRAC]}) + c.offset;
      if (sum < 0)
         return '0;
      else if (sum > $signed({3'h0, {DW{1'b1}}}))
         return '1;
      else
         return sum[DW-1:0];
   endfunction : proc_sample

   // Pin synchronisers.
   logic [DW-1:0] ain_meta_r [3];
   logic [DW-1:0] ain_s_r    [3];
   logic [2:0]    pck_r;
   logic [2:0]    lsi_r;

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ain_meta_r <= '{default: '0};
         ain_s_r    <= '{default: '0};
         pck_r      <= '0;
         lsi_r      <= '0;
      end
      else
      begin
         ain_meta_r <= '{red_analog_input_i, green_analog_input_i, blue_analog_input_i};
         ain_s_r    <= ain_meta_r;
         pck_r      <= {pck_r[1:0], input_pixel_clock_i};
         lsi_r      <= {lsi_r[1:0], external_line_start_input_i};
      end
   end

   // The line-start and pixel-clock edges are the timing references for the sequence.
   wire pix_evt = pck_r[1] && !pck_r[2];
   wire ls_evt  = lsi_r[1] && !lsi_r[2]; // RQ11

   // Configuration decode.
   logic [7:0]    operating_mode_config_r;
   wire  [1:0]    sel_f  = operating_mode_config_r[`AMCS_SEL_HI:`AMCS_SEL_LO]; // RQ1
   wire           rev_f  = operating_mode_config_r[`AMCS_REV_BIT]; // RQ1
   wire  [2:0]    len_f  = operating_mode_config_r[`AMCS_LEN_HI:`AMCS_LEN_LO]; // RQ1
   amcs_mode_t    mode;
   assign mode = decode_mode(operating_mode_config_r[`AMCS_MODE_HI:`AMCS_MODE_LO]); // RQ1

   // Out-of-range lengths are clamped rather than refused.
   wire  [2:0]    len1 = (len_f == 3'h0) ? 3'h1 :
                         (len_f > `AMCS_MAX_COLORS) ? `AMCS_MAX_COLORS : len_f; // RQ1
   wire  [2:0]    seq_len = (mode == amcs_mode_line3) ? `AMCS_SEQ3_LEN :
                            (mode == amcs_mode_line1) ? len1 : 3'h1;
   wire  [1:0]    nch = (mode == amcs_mode_pix3) ? 2'h3 :
                        (mode == amcs_mode_pix2) ? 2'h2 : 2'h1; // RQ2
   wire  [1:0]    pair_a = (sel_f == 2'h1) ? 2'h1 : 2'h0;
   wire  [1:0]    pair_b = (sel_f == 2'h0) ? 2'h1 : 2'h2;

   // Sequencer state.
   amcs_state_t   state_r;
   amcs_state_t   state_nxt;
   logic [1:0]    pix_ptr_r;
   logic [2:0]    col_ptr_r;
   logic          first_line_r;
   logic          line_first_r;
   logic          overrun_r;
   logic [1:0]    mux_sel_r;
   logic          line_pulse_r;
   logic [DW-1:0] smp_r [3];

   wire  [1:0]    cur_ch = (mode == amcs_mode_pix3) ?
                              (rev_f ? 2'(2'h2 - pix_ptr_r) : pix_ptr_r) : // RQ7
                           (mode == amcs_mode_pix2) ?
                              ((pix_ptr_r[0] ^ rev_f) ? pair_b : pair_a) : // RQ2
                           (mode == amcs_mode_line1) ?
                              ((sel_f == 2'h0) ? 2'h0 : (sel_f == 2'h1) ? 2'h1 : 2'h2) :
                              (rev_f ? 2'(3'h2 - col_ptr_r) : col_ptr_r[1:0]); // RQ3
   wire           multi  = (mode == amcs_mode_line1) && (cur_ch == 2'h0);
   wire  [2:0]    cur_set = multi ? (rev_f ? 3'(seq_len - 3'h1 - col_ptr_r) : col_ptr_r) :
                            {1'b0, cur_ch}; // RQ5 RQ10
   wire           burst  = clk_ratio_3x_i && (nch != 2'h1); // RQ8
   wire           last   = (pix_ptr_r == 2'(nch - 2'h1));
   wire           start  = (state_r == amcs_st_idle) && pix_evt && !ls_evt && !cfg_wr_i;
   wire           fifo_in_ready;
   wire           fifo_in_valid = (state_r == amcs_st_issue) && !ls_evt && !cfg_wr_i;
   wire           push   = fifo_in_valid && fifo_in_ready;
   wire           ovr_set = pix_evt && (state_r == amcs_st_issue);
   wire  [2:0]    col_nxt = (col_ptr_r == 3'(seq_len - 3'h1)) ? 3'h0 : col_ptr_r + 3'h1;

   amcs_conv_t    conv_in;
   assign conv_in.channel    = cur_ch;
   assign conv_in.coef_set   = cur_set;
   assign conv_in.line_first = line_first_r;
   assign conv_in.data       = proc_sample(smp_r[cur_ch], coef_i[cur_set]); // RQ5 RQ6

   always_comb
   begin
      state_nxt = state_r;
      if (ls_evt || cfg_wr_i)
         state_nxt = amcs_st_idle; // RQ12
      else if (start)
         state_nxt = amcs_st_issue;
      else if (push)
         state_nxt = (burst && !last) ? amcs_st_issue : amcs_st_idle; // RQ8 RQ9
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         operating_mode_config_r <= `AMCS_CFG_RST;
         state_r      <= amcs_st_idle;
         overrun_r    <= 1'b0;
         line_pulse_r <= 1'b0;
      end
      else
      begin
         if (cfg_wr_i)
            operating_mode_config_r <= cfg_wdata_i;
         state_r      <= state_nxt;
         overrun_r    <= ovr_set || (overrun_r && !cfg_wr_i);
         line_pulse_r <= ls_evt;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pix_ptr_r    <= 2'h0;
         col_ptr_r    <= 3'h0;
         first_line_r <= 1'b1;
         line_first_r <= 1'b0;
         mux_sel_r    <= 2'h0;
      end
      else if (cfg_wr_i)
      begin
         pix_ptr_r    <= 2'h0;
         col_ptr_r    <= 3'h0;
         first_line_r <= 1'b1;
      end
      else if (ls_evt)
      begin
         pix_ptr_r    <= 2'h0; // RQ12 RQ7
         col_ptr_r    <= first_line_r ? 3'h0 : col_nxt; // RQ10 RQ3
         first_line_r <= 1'b0;
         line_first_r <= 1'b1;
      end
      else if (push)
      begin
         pix_ptr_r    <= last ? 2'h0 : pix_ptr_r + 2'h1; // RQ2
         line_first_r <= 1'b0;
         mux_sel_r    <= cur_ch; // RQ6
      end
   end

   // All three inputs are caught in one edge so the channels share an instant.
   always_ff @(posedge clock_i)
   begin
      if (start && pix_ptr_r == 2'h0)
         smp_r <= ain_s_r; // RQ4
   end

   amcs_fifo #(
      .WIDTH ($bits(amcs_conv_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock_i     (clock_i),
      .rst_i       (rst_i),
      .in_valid_i  (fifo_in_valid),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (conv_in),
      .out_valid_o (conv_valid_o),
      .out_ready_i (conv_ready_i),
      .out_data_o  (conv_o)
   );

   assign cfg_rdata_o        = operating_mode_config_r;
   assign line_start_pulse_o = line_pulse_r;
   assign adc_strobe_o       = push;
   assign mux_sel_o          = mux_sel_r;
   assign status_o.mode      = mode;
   assign status_o.busy      = (state_r == amcs_st_issue);
   assign status_o.overrun   = overrun_r;
   assign status_o.pix_ptr   = pix_ptr_r;
   assign status_o.col_ptr   = col_ptr_r;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   ptr_bound_a: assert property (pix_ptr_r < nch) // RQ2
      else $error("Pixel pointer beyond active channel count.");
   col_bound_a: assert property (col_ptr_r < seq_len || $past(cfg_wr_i)) // RQ3
      else $error("Colour pointer beyond sequence length.");
   line_reset_a: assert property (ls_evt && !cfg_wr_i |=>
                                  pix_ptr_r == 2'h0 && state_r == amcs_st_idle) // RQ12
      else $error("Line start did not restart the pixel order.");
   joint_sample_a: assert property (start && pix_ptr_r == 2'h0 |=>
                                    smp_r[0] == $past(ain_s_r[0]) &&
                                    smp_r[1] == $past(ain_s_r[1]) &&
                                    smp_r[2] == $past(ain_s_r[2])) // RQ4
      else $error("Inputs not captured in the same cycle.");
   own_coef_a: assert property (push && mode != amcs_mode_line1 |->
                                conv_in.coef_set == {1'b0, conv_in.channel}) // RQ5
      else $error("Pixel mode used another channel's coefficients.");
   mux_follow_a: assert property (push |=> mux_sel_o == $past(cur_ch)) // RQ6
      else $error("Selector does not match the converted channel.");
   rgb_order_a: assert property (push && mode == amcs_mode_pix3 |->
                                 cur_ch == (rev_f ? 2'(2'h2 - pix_ptr_r) : pix_ptr_r)) // RQ7
      else $error("Three-channel order is wrong.");
   burst_run_a: assert property (push && burst && !last && !ls_evt |=>
                                 state_r == amcs_st_issue) // RQ8
      else $error("3x burst ended early.");
   single_conv_a: assert property (push && !clk_ratio_3x_i |=> state_r == amcs_st_idle) // RQ9
      else $error("1x mode issued more than one conversion per pixel.");
   coef_step_a: assert property (ls_evt && !cfg_wr_i && !first_line_r |=>
                                 col_ptr_r == $past(col_nxt)) // RQ10
      else $error("Line start did not step the colour sequence.");

   burst3_c: cover property (push && burst ##1 push ##1 push && mode == amcs_mode_pix3);
   rev2_c: cover property (push && mode == amcs_mode_pix2 && rev_f);
   five_wrap_c: cover property (ls_evt && mode == amcs_mode_line1 && col_ptr_r == 3'h4);
   overrun_c: cover property (ovr_set);
endmodule : amcs_sequencer

/* File: shared/amcs_pkg.sv */
// Types shared by the mode and channel sequencer.
`include "amcs_regs.svh"
package amcs_pkg;
   typedef enum logic [1:0] {
      amcs_mode_line3,
      amcs_mode_line1,
      amcs_mode_pix2,
      amcs_mode_pix3
   } amcs_mode_t;

   typedef enum logic {
      amcs_st_idle,
      amcs_st_issue
   } amcs_state_t;

   typedef struct packed {
      logic        [`AMCS_GAIN_W-1:0]   gain;
      logic signed [`AMCS_OFFSET_W-1:0] offset;
   } amcs_coef_t;

   typedef struct packed {
      logic [1:0]              channel;
      logic [2:0]              coef_set;
      logic                    line_first;
      logic [`AMCS_DATA_W-1:0] data;
   } amcs_conv_t;

   typedef struct packed {
      amcs_mode_t mode;
      logic       busy;
      logic       overrun;
      logic [1:0] pix_ptr;
      logic [2:0] col_ptr;
   } amcs_status_t;
endpackage : amcs_pkg

/* File: shared/amcs_regs.svh */
// Constants of the mode and channel sequencer: field positions, reset values and sizes.
// Behaviour
// [RQ1] Decode mode, inputs, order and length fields.
// [RQ2] Pixel modes interleave one pixel per channel.
// [RQ3] Line modes step colour sequence, forward or reverse.
// [RQ4] Three-channel mode samples all inputs together.
// [RQ5] Each channel uses its own gain and offset; code gives channel 0 in line1 mode the set at col_ptr_r, or at seq_len-1-col_ptr_r when rev_f is set.
// [RQ6] Three-to-one selector feeds converter per sample.
// [RQ7] Order red-green-blue or reversed, line aligned.
// [RQ8] 3x clock gives three conversions per pixel; code gives nch: two in two-channel mode, one in line modes.
// [RQ9] 1x clock gives one conversion per pixel.
// [RQ10] Line start advances the coefficient set.
// [RQ11] Sensor side drives each line-start pulse.
// [RQ12] Line start resets pixel pointer to first.
`ifndef AMCS_REGS_SVH
`define AMCS_REGS_SVH
`define AMCS_MODE_HI      7
`define AMCS_MODE_LO      6
`define AMCS_SEL_HI       5
`define AMCS_SEL_LO       4
`define AMCS_REV_BIT      3
`define AMCS_LEN_HI       2
`define AMCS_LEN_LO       0
`define AMCS_CFG_RST      8'hf1
`define AMCS_MAX_COLORS   3'h5
`define AMCS_SEQ3_LEN     3'h3
`define AMCS_DATA_W       16
`define AMCS_GAIN_W       8
`define AMCS_OFFSET_W     10
`define AMCS_GAIN_FRAC    6
`define AMCS_NUM_SETS     5
`define AMCS_FIFO_DEPTH   8
`endif

/* File: verif/amcs_sensor_model.sv */
// Behavioural image sensor that drives line starts, pixel clocks and sample words.
`timescale 1ns/1ps

module amcs_sensor_model (
   // Clock of the bench, used only to place pin changes
   input  wire logic        clock_i,
   // Sensor pins
   output logic             pix_clk_o,
   output logic             line_o,
   output logic [15:0]      red_o,
   output logic [15:0]      green_o,
   output logic [15:0]      blue_o
);
   initial
   begin
      pix_clk_o = 1'b0;
      line_o    = 1'b0;
      red_o     = 16'h0000;
      green_o   = 16'h0000;
      blue_o    = 16'h0000;
   end

   // The sensor alone decides when a line begins; its spacing sets integration time.
   task automatic line_start();
      @(negedge clock_i) line_o = 1'b1;
      repeat (4) @(negedge clock_i);
      line_o = 1'b0;
      repeat (6) @(negedge clock_i);
   endtask : line_start

   // Words change every pixel so a stale capture cannot pass for a fresh one.
   task automatic pixel(input logic [15:0] s);
      @(negedge clock_i);
      red_o     = s;
      green_o   = s + 16'h0001;
      blue_o    = s + 16'h0002;
      pix_clk_o = 1'b1;
      repeat (6) @(negedge clock_i);
      pix_clk_o = 1'b0;
      repeat (4) @(negedge clock_i);
      red_o   = ~red_o;
      green_o = ~green_o;
      blue_o  = ~blue_o;
   endtask : pixel
endmodule : amcs_sensor_model

/* File: verif/amcs_sequencer_tb_top.sv */
// Self-checking bench for the mode and channel sequencer.
`timescale 1ns/1ps

module amcs_sequencer_tb_top;
   import amcs_pkg::*;
   logic               clock_i;
   logic               rst_i;
   logic               cfg_wr_i;
   logic [7:0]         cfg_wdata_i;
   logic [7:0]         cfg_rdata_o;
   logic               clk_ratio_3x_i;
   amcs_coef_t [4:0]   coef_i;
   amcs_status_t       status_o;
   logic               pix_w;
   logic               line_w;
   logic [15:0]        red_w;
   logic [15:0]        green_w;
   logic [15:0]        blue_w;
   logic               line_start_pulse_o;
   logic               adc_strobe_o;
   logic [1:0]         mux_sel_o;
   logic               conv_valid_o;
   logic               conv_ready_i;
   amcs_conv_t         conv_o;
   amcs_conv_t         got[$];
   int                 miscompares = 0;
   int                 cmp_count = 0;
   int                 strobes = 0;
   int                 lines = 0;

   amcs_sequencer i_dut (
      .clock_i(clock_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i),
      .cfg_rdata_o(cfg_rdata_o), .clk_ratio_3x_i(clk_ratio_3x_i), .coef_i(coef_i),
      .status_o(status_o), .input_pixel_clock_i(pix_w), .external_line_start_input_i(line_w),
      .red_analog_input_i(red_w), .green_analog_input_i(green_w),
      .blue_analog_input_i(blue_w), .line_start_pulse_o(line_start_pulse_o),
      .adc_strobe_o(adc_strobe_o), .mux_sel_o(mux_sel_o), .conv_valid_o(conv_valid_o),
      .conv_ready_i(conv_ready_i), .conv_o(conv_o));

   amcs_sensor_model i_sensor (
      .clock_i(clock_i), .pix_clk_o(pix_w), .line_o(line_w), .red_o(red_w),
      .green_o(green_w), .blue_o(blue_w));

   initial
   begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   always @(posedge clock_i)
   begin
      if (conv_valid_o === 1'b1 && conv_ready_i === 1'b1)
         got.push_back(conv_o);
      if (adc_strobe_o === 1'b1)
         strobes++;
      if (line_start_pulse_o === 1'b1)
         lines++;
   end

   task automatic results();
      if (miscompares == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic write_cfg(input logic [7:0] v, input logic r3);
      @(negedge clock_i);
      cfg_wr_i       = 1'b1;
      cfg_wdata_i    = v;
      clk_ratio_3x_i = r3;
      @(negedge clock_i);
      cfg_wr_i = 1'b0;
   endtask : write_cfg

   // Gain is unsigned with six fraction bits; the sum is clamped to the word range.
   function automatic logic [15:0] exp_data(input logic [15:0] s, input amcs_coef_t c);
      longint v;
      v = (longint'(s) * longint'(c.gain)) >>> 6;
      v = v + longint'($signed(c.offset));
      if (v < 0)
         v = 0;
      if (v > 65535)
         v = 65535;
      return v[15:0];
   endfunction : exp_data

   task automatic expect_conv(input int ch, input int set, input logic first,
                              input logic [15:0] s);
      amcs_conv_t c;
      int         n;
      n = 0;
      while (got.size() == 0 && n < 300)
      begin
         @(negedge clock_i);
         n++;
      end
      if (got.size() == 0)
      begin
         miscompares++;
         results();
      end
      c = got.pop_front();
      check(c.channel, ch[1:0]);
      check(c.coef_set, set[2:0]);
      check(c.line_first, first);
      check(c.data, exp_data(s + 16'(ch), coef_i[set]));
   endtask : expect_conv

   task automatic t_reset();
      check(cfg_rdata_o, 8'hf1);
      check(status_o.mode, amcs_mode_pix3);
      check(conv_valid_o, 1'b0);
   endtask : t_reset

   // A reset in mid-run must bring register and outputs back to their power-up values.
   task automatic t_reset_mid();
      write_cfg(8'h5b, 1'b0);
      check(status_o.overrun, 1'b0);
      check(mux_sel_o, 2'h2);
      @(negedge clock_i);
      rst_i = 1'b1;
      repeat (2) @(negedge clock_i);
      rst_i = 1'b0;
      @(negedge clock_i);
      t_reset();
      check(mux_sel_o, 2'h0);
   endtask : t_reset_mid

   // Line-sequential mode takes one input per line in turn.
   task automatic t_line3(input logic rev);
      write_cfg({4'h3, rev, 3'h0}, 1'b1);
      for (int i = 0; i < 3; i++)
      begin
         i_sensor.line_start();
         i_sensor.pixel(16'h3000);
         expect_conv(rev ? 2 - i : i, rev ? 2 - i : i, 1'b1, 16'h3000);
      end
      check(status_o.col_ptr, 3'h2);
   endtask : t_line3

   task automatic t_modes();
      for (int m = 0; m < 4; m++)
      begin
         write_cfg({m[1:0], 6'h2b}, 1'b1);
         check(cfg_rdata_o, {m[1:0], 6'h2b});
         check(status_o.mode, m[1:0]);
      end
   endtask : t_modes

   task automatic t_pix3_3x(input logic rev);
      int s0;
      write_cfg({4'hf, rev, 3'h1}, 1'b1);
      i_sensor.line_start();
      s0 = strobes;
      i_sensor.pixel(16'h1230);
      check(strobes - s0, 3);
      check(mux_sel_o, rev ? 2'h0 : 2'h2);
      for (int i = 0; i < 3; i++)
         expect_conv(rev ? 2 - i : i, rev ? 2 - i : i, i == 0, 16'h1230);
   endtask : t_pix3_3x

   // A line start after two pixels must bring the order back to red.
   task automatic t_pix3_1x();
      write_cfg(8'hf1, 1'b0);
      i_sensor.line_start();
      i_sensor.pixel(16'h0400);
      i_sensor.pixel(16'h0400);
      check(status_o.pix_ptr, 2'h2);
      i_sensor.line_start();
      i_sensor.pixel(16'h0400);
      expect_conv(0, 0, 1'b1, 16'h0400);
      expect_conv(1, 1, 1'b0, 16'h0400);
      expect_conv(0, 0, 1'b1, 16'h0400);
   endtask : t_pix3_1x

   // Fresh coefficients show that each channel reads its own set.
   task automatic t_pix2();
      coef_i[1].gain   = 8'h50;
      coef_i[2].offset = 10'h3e0;
      write_cfg(8'h91, 1'b1);
      i_sensor.line_start();
      i_sensor.pixel(16'h8000);
      expect_conv(1, 1, 1'b1, 16'h8000);
      expect_conv(2, 2, 1'b0, 16'h8000);
   endtask : t_pix2

   task automatic t_line1(input logic rev);
      int l0;
      write_cfg({4'h4, rev, 3'h3}, 1'b1);
      l0 = lines;
      for (int i = 0; i < 4; i++)
      begin
         i_sensor.line_start();
         i_sensor.pixel(16'h2000);
         expect_conv(0, rev ? 2 - (i % 3) : i % 3, 1'b1, 16'h2000);
      end
      check(lines - l0, 4);
   endtask : t_line1

   // Nine conversions against a stalled drain: eight fit, the ninth must wait.
   // A pixel edge that arrives while stalled is dropped and flagged.
   task automatic t_fifo();
      int s0;
      write_cfg(8'hf1, 1'b1);
      i_sensor.line_start();
      conv_ready_i = 1'b0;
      s0 = strobes;
      repeat (3) i_sensor.pixel(16'h0100);
      check(strobes - s0, 8);
      check(conv_valid_o, 1'b1);
      i_sensor.pixel(16'h0100);
      check(status_o.busy, 1'b1);
      check(status_o.overrun, 1'b1);
      check(strobes - s0, 8);
      conv_ready_i = 1'b1;
      for (int i = 0; i < 9; i++)
         expect_conv(i % 3, i % 3, i == 0, 16'h0100);
   endtask : t_fifo

   initial
   begin
      rst_i          = 1'b1;
      cfg_wr_i       = 1'b0;
      cfg_wdata_i    = 8'h00;
      clk_ratio_3x_i = 1'b1;
      conv_ready_i   = 1'b1;
      for (int k = 0; k < 5; k++)
      begin
         coef_i[k].gain   = 8'h20 + 8'(k * 16);
         coef_i[k].offset = 10'(k * 24) - 10'h00a;
      end
      repeat (5) @(negedge clock_i);
      rst_i = 1'b0;
      @(negedge clock_i);
      t_reset();
      t_modes();
      t_pix3_3x(1'b0);
      t_pix3_3x(1'b1);
      t_pix3_1x();
      t_pix2();
      t_line1(1'b0);
      t_line1(1'b1);
      t_fifo();
      t_reset_mid();
      t_line3(1'b0);
      t_line3(1'b1);
      results();
   end
endmodule : amcs_sequencer_tb_top
